// ==== design/trs_pkg.sv ====
// Shared constants and types for the tape rewind and unload sequencer
package trs_pkg;
	// Register port geometry and byte offsets
	localparam int          ADDR_W    = 4;
	localparam int          DATA_W    = 32;
	localparam logic [3:0]  CTRL_OFS  = 4'h0;
	localparam logic [3:0]  STAT_OFS  = 4'h4;
	// Control register fields and reset value
	localparam int          CTRL_GO   = 0;
	localparam int          CTRL_RDY  = 1;
	localparam int          CTRL_FAST = 2;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0004;
	// Status register field positions
	localparam int          STAT_ST   = 8;
	// Synchronised pins, one bit each
	typedef struct packed {
		logic reset_pb;
		logic unload_pb;
		logic rewind_pb;
		logic left_speed_ok;
		logic right_speed_ok;
		logic upper_left_column_sensor;
		logic lower_right_column_sensor;
		logic lowest_left_column_sensor;
		logic lowest_right_column_sensor;
		logic radius_marker;
		logic reel_seat_switch;
		logic load_point_marker;
		logic medium_sense;
		logic cartridge_fitted;
	} trs_pins_s;
	// Motor, solenoid and lamp drives
	typedef struct packed {
		logic capstan_low_speed;
		logic reel_high_power;
		logic field_reduce;
		logic capstan_coast;
		logic rewind_drive;
		logic right_reel_ccw;
		logic left_reel_cw;
		logic left_reel_ccw;
		logic transfer_valve;
		logic cartridge_close;
		logic pneumatic_off;
		logic ready_lamp;
	} trs_drive_s;
	// Sequencer states
	typedef enum logic [2:0] {
		TRS_IDLE, TRS_RW_QUAL, TRS_RW_FAST, TRS_RW_SLOW,
		TRS_UL_PULL, TRS_UL_XFER, TRS_UL_WIND, TRS_UL_DONE
	} trs_state_e;
endpackage : trs_pkg

// ==== design/trs_seq.sv ====
// Rewind and unload sequencer of a reel-to-reel tape drive
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module trs_seq (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	// Register port
	input  wire logic [trs_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [trs_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [trs_pkg::DATA_W-1:0]  reg_rdata,
	// Pushbuttons and sensors
	input  wire trs_pkg::trs_pins_s          pins,
	// Drives
	output trs_pkg::trs_drive_s              drive
);
	localparam int NP = $bits(trs_pkg::trs_pins_s);

	logic [NP-1:0]          s1_reg, s2_reg, s3_reg;
	trs_pkg::trs_pins_s     pin_reg, pin_next, prv_reg, rise;
	trs_pkg::trs_state_e    st_reg, st_next;
	trs_pkg::trs_drive_s    drv_next;
	logic [31:0]            ctrl_reg, ctrl_next;
	logic                   manual_reg, rwul_reg, unload_in_progress;
	logic                   ready_reg, fast_rewind_latch;
	logic                   cols_reg, med_reg, done_reg;
	logic                   go_pulse, speed_ok, qual_fast, stop_pulse;
	logic                   ul_start, rewinding, wr_ctrl, fast_en;

	// Three-stage synchroniser; a bit changes once stages 2 and 3 agree
	assign pin_next = (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			pin_reg <= '0;
			prv_reg <= '0;
		end
		else
		begin
			s1_reg  <= pins;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			pin_reg <= pin_next;
			prv_reg <= pin_reg;
		end
	end

	// Edge events from registered pins
	assign rise       = pin_reg & ~prv_reg;
	assign wr_ctrl    = reg_wr && reg_addr == trs_pkg::CTRL_OFS;
	assign go_pulse   = rise.rewind_pb | (wr_ctrl & reg_wdata[trs_pkg::CTRL_GO]);
	assign fast_en    = ctrl_reg[trs_pkg::CTRL_FAST];
	assign speed_ok   = pin_reg.left_speed_ok & pin_reg.right_speed_ok;
	assign qual_fast  = st_reg == trs_pkg::TRS_RW_QUAL && speed_ok && fast_en;
	assign stop_pulse = rise.radius_marker & fast_rewind_latch;
	assign ul_start   = rise.unload_pb && st_reg == trs_pkg::TRS_IDLE;
	assign rewinding  = st_reg == trs_pkg::TRS_RW_QUAL ||
		st_reg == trs_pkg::TRS_RW_FAST || st_reg == trs_pkg::TRS_RW_SLOW;

	// Control register: go and ready-set are write pulses, not stored
	assign ctrl_next = wr_ctrl ? (reg_wdata & trs_pkg::CTRL_RST) : ctrl_reg;

	// Sequencer next state
	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			trs_pkg::TRS_IDLE:
				if (ul_start)
					st_next = pin_reg.load_point_marker ?
						trs_pkg::TRS_UL_PULL : trs_pkg::TRS_RW_QUAL;
				else if (go_pulse)
					st_next = trs_pkg::TRS_RW_QUAL;
			trs_pkg::TRS_RW_QUAL:
				if (pin_reg.load_point_marker)
					st_next = unload_in_progress ?
						trs_pkg::TRS_UL_PULL : trs_pkg::TRS_IDLE;
				else if (qual_fast)
					st_next = trs_pkg::TRS_RW_FAST;
			trs_pkg::TRS_RW_FAST:
				if (stop_pulse)
					st_next = trs_pkg::TRS_RW_SLOW;
			trs_pkg::TRS_RW_SLOW:
				if (pin_reg.load_point_marker)
					st_next = unload_in_progress ?
						trs_pkg::TRS_UL_PULL : trs_pkg::TRS_IDLE;
			trs_pkg::TRS_UL_PULL:
				if (pin_reg.upper_left_column_sensor)
					st_next = trs_pkg::TRS_UL_XFER;
			trs_pkg::TRS_UL_XFER:
				if (pin_reg.reel_seat_switch)
					st_next = trs_pkg::TRS_UL_WIND;
			trs_pkg::TRS_UL_WIND:
				if (done_reg)
					st_next = trs_pkg::TRS_UL_DONE;
			trs_pkg::TRS_UL_DONE:
				if (rise.reset_pb)
					st_next = trs_pkg::TRS_IDLE;
			default:
				st_next = trs_pkg::TRS_IDLE;
		endcase
	end

	// State, control and sequence flags
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg             <= trs_pkg::TRS_IDLE;
			ctrl_reg           <= trs_pkg::CTRL_RST;
			manual_reg         <= 1'b0;
			rwul_reg           <= 1'b0;
			unload_in_progress <= 1'b0;
			fast_rewind_latch  <= 1'b0;
		end
		else
		begin
			st_reg   <= st_next;
			ctrl_reg <= ctrl_next;
			if (ul_start)
			begin
				manual_reg         <= 1'b1;
				rwul_reg           <= 1'b1;
				unload_in_progress <= 1'b1;
			end
			else if (st_next == trs_pkg::TRS_IDLE)
			begin
				manual_reg         <= 1'b0;
				rwul_reg           <= 1'b0;
				unload_in_progress <= 1'b0;
			end
			if (stop_pulse)
				fast_rewind_latch <= 1'b0;
			else if (qual_fast)
				fast_rewind_latch <= 1'b1;
		end
	end

	// Ready latch, column, medium and completion flags
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ready_reg <= 1'b0;
			cols_reg  <= 1'b0;
			med_reg   <= 1'b0;
			done_reg  <= 1'b0;
		end
		else
		begin
			if (rise.reset_pb)
				ready_reg <= 1'b0;
			else if (wr_ctrl && reg_wdata[trs_pkg::CTRL_RDY])
				ready_reg <= 1'b1;
			cols_reg <= ~pin_reg.lowest_left_column_sensor &
				~pin_reg.lowest_right_column_sensor;
			med_reg  <= pin_reg.medium_sense;
			done_reg <= cols_reg & ~med_reg & unload_in_progress;
		end
	end

	// Drive decode from state, flags and synchronised pins
	always_comb
	begin
		drv_next = '0;
		drv_next.capstan_low_speed = st_reg == trs_pkg::TRS_RW_QUAL;
		drv_next.reel_high_power   = rewinding;
		drv_next.rewind_drive      = rewinding;
		drv_next.field_reduce      = fast_rewind_latch;
		drv_next.capstan_coast     = fast_rewind_latch &
			(pin_reg.upper_left_column_sensor |
			 pin_reg.lower_right_column_sensor);
		drv_next.right_reel_ccw    = (st_reg == trs_pkg::TRS_UL_PULL &&
			unload_in_progress && manual_reg) ||
			st_reg == trs_pkg::TRS_UL_WIND;
		drv_next.left_reel_cw      = st_reg == trs_pkg::TRS_UL_XFER;
		drv_next.left_reel_ccw     = st_reg == trs_pkg::TRS_UL_WIND;
		drv_next.transfer_valve    = st_reg == trs_pkg::TRS_UL_XFER ||
			st_reg == trs_pkg::TRS_UL_WIND;
		drv_next.cartridge_close   = done_reg &
			pin_reg.cartridge_fitted;
		drv_next.pneumatic_off     = done_reg;
		drv_next.ready_lamp        = ready_reg;
	end

	// Registered drives and read data
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drive     <= '0;
			reg_rdata <= '0;
		end
		else
		begin
			drive <= drv_next;
			if (!reg_rd)
				reg_rdata <= '0;
			else if (reg_addr == trs_pkg::CTRL_OFS)
				reg_rdata <= ctrl_reg;
			else if (reg_addr == trs_pkg::STAT_OFS)
				reg_rdata <= {21'h0, st_reg, done_reg, med_reg, cols_reg,
					ready_reg, fast_rewind_latch, unload_in_progress,
					rwul_reg, manual_reg};
			else
				reg_rdata <= '0;
		end
	end

	// Checks on the rewind path, the flags, the transfer step and cartridge close
	fast_qual_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		$rose(fast_rewind_latch) |-> $past(speed_ok))
		else $error("fast rewind without speed qualification");
	cap_low_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		st_reg == trs_pkg::TRS_RW_QUAL
		|=> drive.capstan_low_speed && drive.reel_high_power)
		else $error("rewind start drives wrong");
	field_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		fast_rewind_latch |=> drive.field_reduce)
		else $error("field not reduced in fast rewind");
	coast_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		drive.capstan_coast |-> $past(fast_rewind_latch))
		else $error("coast outside fast rewind");
	stop_clear_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		stop_pulse |=> !fast_rewind_latch ##1 !drive.field_reduce)
		else $error("stop pulse did not clear latch");
	flags_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		ul_start |=> manual_reg && rwul_reg && unload_in_progress)
		else $error("unload flags not set together");
	valve_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		drive.left_reel_cw |-> drive.transfer_valve && !drive.right_reel_ccw)
		else $error("transfer step drives wrong");
	done_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		done_reg |-> $past(cols_reg) && !$past(med_reg))
		else $error("unload done without cause");
	close_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		drive.cartridge_close
		|-> drive.pneumatic_off && $past(pin_reg.cartridge_fitted))
		else $error("cartridge closed without completion or cartridge");
	ready_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		rise.reset_pb |=> !ready_reg ##1 !drive.ready_lamp)
		else $error("reset button left ready set");

	// Checks on the unload steps; a step's drives follow one cycle late
	pull_reel_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		st_reg == trs_pkg::TRS_UL_PULL && unload_in_progress && manual_reg
		|=> drive.right_reel_ccw && !drive.transfer_valve)
		else $error("right reel not pulling tape out");
	valve_on_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		st_reg == trs_pkg::TRS_UL_PULL && pin_reg.upper_left_column_sensor
		|=> st_reg == trs_pkg::TRS_UL_XFER ##1 drive.transfer_valve)
		else $error("transfer valve not energised");
	cols_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		$changed(cols_reg) |-> cols_reg ==
		(!$past(pin_reg.lowest_left_column_sensor) &&
		 !$past(pin_reg.lowest_right_column_sensor)))
		else $error("columns emptied flag wrong");
	wind_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		st_reg == trs_pkg::TRS_UL_WIND
		|=> drive.left_reel_ccw && drive.right_reel_ccw)
		else $error("wind step drives wrong");
	pneu_a: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		done_reg |=> drive.pneumatic_off)
		else $error("pneumatics left on after unload");

	// Main scenarios reached
	fast_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
		qual_fast ##[1:1000] stop_pulse);
	unload_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
		st_reg == trs_pkg::TRS_UL_WIND ##1 st_reg == trs_pkg::TRS_UL_DONE);
	rwul_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
		ul_start && !pin_reg.load_point_marker);
	bare_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
		drive.pneumatic_off && !drive.cartridge_close);
endmodule : trs_seq

// ==== sim/trs_drive_model.sv ====
// Behavioural tape, reel and sensor model facing the sequencer drives
`timescale 1ns/1ns
module trs_drive_model (
	// Clock
	input  wire logic                ref_clk,
	// Bench controls: buttons, tape mount, slow reels, column excursions
	input  wire logic [2:0]          btn,
	input  wire logic                mount,
	input  wire logic                stall,
	input  wire logic [1:0]          col,
	input  wire logic                cart,
	// Drives in, sensors out
	input  wire trs_pkg::trs_drive_s drive,
	output trs_pkg::trs_pins_s       pins
);
	trs_pkg::trs_drive_s drv_q;
	logic [7:0]          cnt = 8'h00;
	logic                spd;
	logic                lp;
	logic                seat;
	logic                low;
	logic                med;
	wire                 lp_hit;
	wire                 up;
	// Tape reaches places only after drives hold steady for a while
	assign lp_hit = drive.rewind_drive & ~drive.field_reduce & cnt > 8'h78;
	assign up     = (drive.right_reel_ccw & cnt > 8'h1e) | col[1];
	// Cycles since the drives last changed pace every tape event
	always_ff @(posedge ref_clk)
	begin
		drv_q <= drive;
		cnt   <= (drive === drv_q && cnt != 8'hff) ? cnt + 8'h01 : 8'h00;
		spd   <= drive.reel_high_power & ~stall;
		lp    <= ~mount & (lp | lp_hit);
		seat  <= ~mount & (seat | (drive.left_reel_cw & cnt > 8'h1e));
		low   <= mount | (low & ~(drive.left_reel_cw & cnt > 8'h14));
		med   <= mount | (med & ~(drive.left_reel_ccw & drive.right_reel_ccw
			& cnt > 8'h1e));
	end
	// Pins in struct order; radius marker shows late in a fast rewind
	assign pins = {btn, spd, spd, up, col[0], low, low,
		drive.field_reduce & cnt > 8'h50, seat, lp, med, cart};
endmodule : trs_drive_model

// ==== sim/trs_seq_test.sv ====
// Self-checking bench for the rewind and unload sequencer
`timescale 1ns/1ns
module trs_seq_test;
	logic                ref_clk   = 1'h0;
	logic                rst_b     = 1'h0;
	logic [3:0]          reg_addr  = 4'h0;
	logic [31:0]         reg_wdata = 32'h0;
	logic                reg_wr    = 1'h0;
	logic                reg_rd    = 1'h0;
	logic [2:0]          btn       = 3'h0;
	logic [1:0]          col       = 2'h0;
	logic                mount     = 1'h1;
	logic                stall     = 1'h0;
	logic                cart      = 1'h1;
	logic [31:0]         reg_rdata;
	logic [31:0]         st;
	trs_pkg::trs_pins_s  pins;
	trs_pkg::trs_drive_s drive;
	int                  mismatches = 0;
	int                  compares   = 0;
	// Clock, design and far side
	always #5 ref_clk = ~ref_clk;
	trs_seq dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pins(pins), .drive(drive));
	trs_drive_model model (.ref_clk(ref_clk), .btn(btn), .mount(mount),
		.stall(stall), .col(col), .cart(cart), .drive(drive), .pins(pins));
	// Bus cycles, waits and comparisons
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge ref_clk);
		reg_wr    <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge ref_clk);
		reg_rd   <= 1'h0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic poll(input logic [2:0] e);
		rd(trs_pkg::STAT_OFS, st);
		for (int i = 0; i < 500 && st[10:8] !== e; i++)
			rd(trs_pkg::STAT_OFS, st);
		chk("state", {29'h0, e}, {29'h0, st[10:8]});
	endtask : poll
	task automatic press(input int b);
		@(posedge ref_clk);
		btn[b] <= 1'h1;
		settle(8);
		@(posedge ref_clk);
		btn[b] <= 1'h0;
		settle(8);
	endtask : press
	task automatic close_out;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// Watchdog against a hung sequence
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		close_out;
	end
	// Reset, rewind, unload at load point, bare unload from mid tape
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		mount <= 1'h0;
		stall <= 1'h1;
		rd(trs_pkg::CTRL_OFS, st);
		chk("ctrl", 32'h4, st);
		chk("drive", 32'h0, {20'h0, drive});
		rd(4'h8, st);
		chk("unmapped", 32'h0, st);
		press(0);
		poll(3'h1);
		chk("qual", 32'h3, {30'h0, drive.capstan_low_speed,
			drive.reel_high_power});
		settle(40);
		poll(3'h1);
		chk("early", 32'h0, {30'h0, st[3], drive.field_reduce});
		@(posedge ref_clk);
		stall <= 1'h0;
		poll(3'h2);
		chk("fast", 32'h3, {30'h0, st[3], drive.field_reduce});
		for (int i = 1; i < 3; i++)
		begin
			@(posedge ref_clk);
			col <= i[1:0];
			settle(8);
			chk("coast", 32'h1, {31'h0, drive.capstan_coast});
			@(posedge ref_clk);
			col <= 2'h0;
			settle(8);
			chk("glide", 32'h0, {31'h0, drive.capstan_coast});
		end
		poll(3'h3);
		chk("slow", 32'h1, {29'h0, st[3], drive.field_reduce,
			drive.rewind_drive});
		poll(3'h0);
		$display("test rewind done");
		wr(trs_pkg::CTRL_OFS, 32'h6);
		rd(trs_pkg::STAT_OFS, st);
		chk("ready", 32'h3, {30'h0, st[4], drive.ready_lamp});
		press(2);
		rd(trs_pkg::STAT_OFS, st);
		chk("unready", 32'h0, {30'h0, st[4], drive.ready_lamp});
		press(1);
		poll(3'h4);
		chk("pull", 32'h1e, {26'h0, st[5], st[2:0], drive.right_reel_ccw,
			drive.transfer_valve});
		poll(3'h5);
		chk("xfer", 32'h5, {29'h0, drive.transfer_valve,
			drive.right_reel_ccw, drive.left_reel_cw});
		poll(3'h6);
		chk("wind", 32'hf, {28'h0, st[6], st[5], drive.left_reel_ccw,
			drive.right_reel_ccw});
		poll(3'h7);
		settle(2);
		rd(trs_pkg::STAT_OFS, st);
		chk("done", 32'hb, {28'h0, st[7], st[6], drive.cartridge_close,
			drive.pneumatic_off});
		press(2);
		poll(3'h0);
		chk("cleared", 32'h0, {29'h0, st[2:0]});
		$display("test unload done");
		@(posedge ref_clk);
		mount <= 1'h1;
		cart  <= 1'h0;
		@(posedge ref_clk);
		mount <= 1'h0;
		press(2);
		press(1);
		poll(3'h2);
		poll(3'h4);
		poll(3'h7);
		settle(2);
		chk("bare", 32'h1, {30'h0, drive.cartridge_close,
			drive.pneumatic_off});
		$display("test bare unload done");
		close_out;
	end
endmodule : trs_seq_test
